// file: rgbcsc_consts.svh
// constants for the colour matrix and chroma downsampler datapath
// assumes inclusion by rgbcsc_pkg and the design modules
`ifndef RGBCSC_CONSTS_SVH
`define RGBCSC_CONSTS_SVH

// configuration locations and bit positions
`define RGBCSC_ADDR_BYPASS   8'h23
`define RGBCSC_BIT_BYPASS    3
`define RGBCSC_ADDR_FORMAT   8'h15
`define RGBCSC_BIT_FORMAT    1
`define RGBCSC_RST_BYPASS    1'h1
`define RGBCSC_RST_FORMAT    1'h0

// matrix defaults, signed, 0x1000 = 0.5 ; columns g, b, r
`define RGBCSC_C_Y_G         16'h16E3
`define RGBCSC_C_Y_B         16'h024F
`define RGBCSC_C_Y_R         16'h06CE
`define RGBCSC_C_PB_G        16'hF3AB
`define RGBCSC_C_PB_B        16'h1000
`define RGBCSC_C_PB_R        16'hFC55
`define RGBCSC_C_PR_G        16'hF178
`define RGBCSC_C_PR_B        16'hFF88
`define RGBCSC_C_PR_R        16'h1000
`define RGBCSC_CSC_FRAC      13
`define RGBCSC_CHROMA_MID    10'h200

// half-band filter, 27 taps, 0x800 = 0.5 centre tap
`define RGBCSC_HB_TAPS       27
`define RGBCSC_HB_MID        13
`define RGBCSC_HB_FRAC       12
`define RGBCSC_HB_CENTRE     13'h0800
`define RGBCSC_HB_H1         13'h04FC
`define RGBCSC_HB_H3         13'h1E7C
`define RGBCSC_HB_H5         13'h00C0
`define RGBCSC_HB_H7         13'h1F99
`define RGBCSC_HB_H9         13'h0035
`define RGBCSC_HB_H11        13'h1FE8
`define RGBCSC_HB_H13        13'h0012

// accepted samples before the first output: 2 + 14 + 1
`define RGBCSC_FILL          5'h11
`define RGBCSC_FIFO_DEPTH    16
`define RGBCSC_FIFO_WIDTH    31

`endif

// file: rgbcsc_pkg.sv
// types shared by the colour matrix datapath
// assumes rgbcsc_consts.svh is on the include path
`include "rgbcsc_consts.svh"
package rgbcsc_pkg;
  typedef logic [9:0]         rgbcsc_sample_t;
  typedef logic signed [15:0] rgbcsc_coef_t;
  typedef logic signed [12:0] rgbcsc_tap_t;

  // round away the fraction and clamp to the 10-bit range
  function automatic rgbcsc_sample_t rgbcsc_sat(input logic signed [31:0] v,
                                                input int unsigned frac);
    logic signed [31:0] r;
    r = (v + (32'sd1 <<< (frac - 1))) >>> frac;
    if (r < 0)
      return 10'h000;
    else if (r > 32'sd1023)
      return 10'h3FF;
    else
      return r[9:0];
  endfunction
endpackage

// file: rgbcsc_fifo_if.sv
// carrier between the datapath and its output fifo
// assumes a single clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface rgbcsc_fifo_if #(parameter int W = 31);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport src  (output wr_valid, input wr_ready, output wr_data,
                input rd_valid, output rd_ready, input rd_data);
  modport fifo (input wr_valid, output wr_ready, input wr_data,
                output rd_valid, input rd_ready, output rd_data);
endinterface
`default_nettype wire

// file: rgbcsc_fifo.sv
// output fifo of the datapath, read data from a register
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module rgbcsc_fifo #(
  parameter int W     = 31,
  parameter int DEPTH = 16
) (
  input  wire logic      clk_sys_in,
  input  wire logic      rst_in,
  rgbcsc_fifo_if.fifo    bus
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          out_valid;
  logic [W-1:0]  out_data;
  logic          push;
  logic          pop;

  assign bus.wr_ready = (count != (AW+1)'(DEPTH));
  assign push         = bus.wr_valid && bus.wr_ready;
  // refill the output register whenever it is empty or being taken
  assign pop          = (count != '0) && (!out_valid || bus.rd_ready);
  assign bus.rd_valid = out_valid;
  assign bus.rd_data  = out_data;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wr_ptr] <= bus.wr_data;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end
    else if (bus.rd_ready)
      out_valid <= 1'b0;
  end
endmodule
`default_nettype wire

// file: rgbcsc_top.sv
// colour matrix, half-band chroma downsampler and output formatter
// assumes samples synchronous to clk_sys_in, one clock, async reset
//
// Behaviour
// - programmable 3x3 matrix converts rgb to ycbcr
// - matrix coefficients reset to high-definition set
// - bypass bit 23h.3, bypass after reset
// - 27-tap half-band filter halves chroma rate
// - 15h.1 selects 30-bit 4:4:4 or 20-bit 4:2:2
// - 4:2:2 puts cb/cr alternately on blue port
// - downsampling follows the colour matrix
// - red port released in 4:2:2 mode
`timescale 1ns/1ps
`default_nettype none
`include "rgbcsc_consts.svh"
module rgbcsc_top
  import rgbcsc_pkg::*;
(
  input  wire logic            clk_sys_in,
  input  wire logic            rst_in,
  input  wire logic            cfg_wr_in,
  input  wire logic [7:0]      cfg_addr_in,
  input  wire logic [7:0]      cfg_data_in,
  input  wire logic            coef_wr_in,
  input  wire logic [3:0]      coef_sel_in,
  input  wire logic [15:0]     coef_data_in,
  input  wire logic            pix_valid_in,
  output logic                 pix_ready_out,
  input  wire logic [9:0]      pix_r_in,
  input  wire logic [9:0]      pix_g_in,
  input  wire logic [9:0]      pix_b_in,
  output logic                 out_valid_out,
  input  wire logic            out_ready_in,
  output logic [9:0]           green_port_out,
  output logic [9:0]           blue_port_out,
  output logic [9:0]           red_port_out,
  output logic                 red_port_oe_out,
  output logic                 bypass_out,
  output logic                 fmt422_out
);
  localparam rgbcsc_tap_t HB [0:6] = '{`RGBCSC_HB_H1, `RGBCSC_HB_H3,
    `RGBCSC_HB_H5, `RGBCSC_HB_H7, `RGBCSC_HB_H9, `RGBCSC_HB_H11,
    `RGBCSC_HB_H13};
  localparam rgbcsc_coef_t CRST [0:8] = '{`RGBCSC_C_Y_G, `RGBCSC_C_Y_B,
    `RGBCSC_C_Y_R, `RGBCSC_C_PB_G, `RGBCSC_C_PB_B, `RGBCSC_C_PB_R,
    `RGBCSC_C_PR_G, `RGBCSC_C_PR_B, `RGBCSC_C_PR_R};

  rgbcsc_fifo_if #(.W(`RGBCSC_FIFO_WIDTH)) fq ();

  rgbcsc_coef_t   coef [0:8];
  logic           bypass;
  logic           fmt422;
  logic           adv;
  logic [4:0]     fill;
  logic           phase;
  rgbcsc_sample_t mat [0:2];
  rgbcsc_sample_t ydl [0:`RGBCSC_HB_MID];
  rgbcsc_sample_t ctap [0:1][0:`RGBCSC_HB_TAPS-1];
  rgbcsc_sample_t cfilt [0:1];
  rgbcsc_sample_t craw [0:1];
  rgbcsc_sample_t yal;
  rgbcsc_sample_t cr_hold;
  logic [29:0]    next_word;

  // the whole pipeline steps only on an accepted sample, so a full
  // fifo stalls the source instead of dropping pixels
  assign adv           = pix_valid_in && fq.wr_ready;
  assign pix_ready_out = fq.wr_ready;
  assign bypass_out    = bypass;
  assign fmt422_out    = fmt422;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bypass <= `RGBCSC_RST_BYPASS;
      fmt422 <= `RGBCSC_RST_FORMAT;
    end
    else if (cfg_wr_in)
    begin
      if (cfg_addr_in == `RGBCSC_ADDR_BYPASS)
        bypass <= cfg_data_in[`RGBCSC_BIT_BYPASS];
      if (cfg_addr_in == `RGBCSC_ADDR_FORMAT)
        fmt422 <= cfg_data_in[`RGBCSC_BIT_FORMAT];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      coef <= CRST;
    else if (coef_wr_in && coef_sel_in < 4'h9)
      coef[coef_sel_in] <= coef_data_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // matrix rows: y, cb, cr ; columns g, b, r
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      mat <= '{default: 10'h000};
    else if (adv)
    begin
      for (int r = 0; r < 3; r++)
      begin
        logic signed [31:0] acc;
        acc = 32'(coef[3*r]   * $signed({1'b0, pix_g_in}))
            + 32'(coef[3*r+1] * $signed({1'b0, pix_b_in}))
            + 32'(coef[3*r+2] * $signed({1'b0, pix_r_in}));
        if (r != 0)
          acc = acc + (32'(`RGBCSC_CHROMA_MID) <<< `RGBCSC_CSC_FRAC);
        mat[r] <= rgbcsc_sat(acc, `RGBCSC_CSC_FRAC);
      end
      if (bypass)
      begin
        mat[0] <= pix_g_in;
        mat[1] <= pix_b_in;
        mat[2] <= pix_r_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // luma waits as long as the filter centre tap
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      ydl <= '{default: 10'h000};
    else if (adv)
    begin
      ydl[0] <= mat[0];
      for (int i = 1; i <= `RGBCSC_HB_MID; i++)
        ydl[i] <= ydl[i-1];
    end
  end

  // one filter per chroma channel, fed by the matrix output
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chroma
    logic signed [31:0] facc;
    always_comb
    begin
      facc = 32'($signed(`RGBCSC_HB_CENTRE))
           * $signed({22'h000000, ctap[ch][`RGBCSC_HB_MID]});
      for (int k = 0; k < 7; k++)
        facc = facc + 32'(HB[k] * $signed({1'b0,
          11'(ctap[ch][`RGBCSC_HB_MID-2*k-1])
          + 11'(ctap[ch][`RGBCSC_HB_MID+2*k+1])}));
    end
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
      if (rst_in)
      begin
        ctap[ch]  <= '{default: 10'h000};
        cfilt[ch] <= 10'h000;
        craw[ch]  <= 10'h000;
      end
      else if (adv)
      begin
        ctap[ch][0] <= mat[ch+1];
        for (int i = 1; i < `RGBCSC_HB_TAPS; i++)
          ctap[ch][i] <= ctap[ch][i-1];
        cfilt[ch] <= rgbcsc_sat(facc, `RGBCSC_HB_FRAC);
        craw[ch]  <= ctap[ch][`RGBCSC_HB_MID];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      yal <= 10'h000;
    else if (adv)
      yal <= ydl[`RGBCSC_HB_MID];
  end

  ////////////////////////////////////////////////////////////////////////
  // fill count keeps start-up garbage out of the fifo
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      fill <= 5'h00;
    else if (adv && fill != `RGBCSC_FILL)
      fill <= fill + 5'h01;
  end

  // even pixel carries cb, odd pixel carries the co-sited cr
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase   <= 1'b0;
      cr_hold <= 10'h000;
    end
    else if (fq.wr_valid)
    begin
      phase <= ~phase;
      if (!phase)
        cr_hold <= cfilt[1];
    end
  end

  always_comb
  begin
    if (fmt422)
      next_word = {yal, (phase ? cr_hold : cfilt[0]), 10'h000};
    else
      next_word = {yal, craw[0], craw[1]};
  end

  assign fq.wr_valid = adv && (fill == `RGBCSC_FILL);
  assign fq.wr_data  = {fmt422, next_word};
  assign fq.rd_ready = out_ready_in;

  rgbcsc_fifo #(
    .W     (`RGBCSC_FIFO_WIDTH),
    .DEPTH (`RGBCSC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .bus        (fq)
  );

  assign out_valid_out   = fq.rd_valid;
  assign green_port_out  = fq.rd_data[29:20];
  assign blue_port_out   = fq.rd_data[19:10];
  assign red_port_out    = fq.rd_data[9:0];
  // red lanes are undriven while the word was built in 4:2:2
  assign red_port_oe_out = !fq.rd_data[30];
endmodule
`default_nettype wire

// file: rgbcsc_assertions.sv
// checker on the top ports of the colour datapath
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module rgbcsc_assertions (
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_data_in,
  input wire logic       out_valid_out,
  input wire logic       out_ready_in,
  input wire logic [9:0] green_port_out,
  input wire logic [9:0] blue_port_out,
  input wire logic [9:0] red_port_out,
  input wire logic       red_port_oe_out,
  input wire logic       bypass_out,
  input wire logic       fmt422_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////
  sequence s_byp_wr;
    cfg_wr_in && cfg_addr_in == 8'h23;
  endsequence
  sequence s_fmt_wr;
    cfg_wr_in && cfg_addr_in == 8'h15;
  endsequence
  sequence s_stall;
    out_valid_out && !out_ready_in;
  endsequence
  ////////////////////////////////////////////////
  byp_write_a: assert property (
    s_byp_wr |=> bypass_out == $past(cfg_data_in[3]))
    else $error("bypass bit not taken");
  fmt_write_a: assert property (
    s_fmt_wr |=> fmt422_out == $past(cfg_data_in[1]))
    else $error("format bit not taken");
  cfg_hold_a: assert property (
    !cfg_wr_in |=> $stable({bypass_out, fmt422_out}))
    else $error("mode bits moved without a write");
  foreign_addr_a: assert property (
    cfg_wr_in && !(cfg_addr_in inside {8'h23, 8'h15})
    |=> $stable({bypass_out, fmt422_out}))
    else $error("write elsewhere moved mode bits");
  word_hold_a: assert property (
    s_stall |=> out_valid_out && $stable({green_port_out,
      blue_port_out, red_port_out, red_port_oe_out}))
    else $error("stalled word changed");
  red_float_a: assert property (
    out_valid_out && !red_port_oe_out |-> red_port_out == 10'h000)
    else $error("released red port not zero");
  reset_state_a: assert property (
    $fell(rst_in) |-> bypass_out && !fmt422_out)
    else $error("mode bits wrong after reset");
  fill_time_a: assert property (
    $fell(rst_in) |-> !out_valid_out [*8])
    else $error("output before pipeline filled");
endmodule
// attach the checker to every top instance
bind rgbcsc_top rgbcsc_assertions i_chk (.clk_sys_in, .rst_in,
  .cfg_wr_in, .cfg_addr_in, .cfg_data_in, .out_valid_out,
  .out_ready_in, .green_port_out, .blue_port_out, .red_port_out,
  .red_port_oe_out, .bypass_out, .fmt422_out);
`default_nettype wire

// file: rgbcsc_sink.sv
// downstream consumer model: takes words, stalls at random
// assumes words qualified by valid and ready at the rising edge
`timescale 1ns/1ps
`default_nettype none
module rgbcsc_sink (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        stall_in,
  input  wire logic        out_valid_in,
  input  wire logic [30:0] word_in,
  output logic             ready_out
);
  logic [7:0]  lfsr;
  logic [30:0] q[$];
  // ready toggles at random so both prompt and slow takes occur
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q.delete();
      ready_out <= 1'b0;
      lfsr <= 8'hA5;
    end
    else
    begin
      if (out_valid_in && ready_out)
        q.push_back(word_in);
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      ready_out <= !stall_in && (lfsr[0] || lfsr[1]);
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// bench for the colour matrix and chroma downsampler
// assumes rgbcsc_sink as consumer; random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rgbcsc_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cfg_wr = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [7:0]  cfg_data = 8'h00;
  logic        coef_wr = 1'b0;
  logic [3:0]  coef_sel = 4'h0;
  logic [15:0] coef_data = 16'h0000;
  logic        pix_valid = 1'b0;
  logic [9:0]  pr = 10'h000;
  logic [9:0]  pg = 10'h000;
  logic [9:0]  pb = 10'h000;
  logic        stall = 1'b0;
  wire logic   pix_ready, out_valid, out_ready, red_oe, byp, f422;
  wire logic [9:0] gp, bp, rp;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  bit          saw_full = 0;
  int unsigned seed = 71271;
  int          cf[9];
  rgbcsc_coef_t dk[9] = '{16'h16E3, 16'h024F, 16'h06CE, 16'hF3AB,
    16'h1000, 16'hFC55, 16'hF178, 16'hFF88, 16'h1000};
  ////////////////////////////////////////////////
  rgbcsc_top i_dut (.clk_sys_in, .rst_in, .cfg_wr_in(cfg_wr),
    .cfg_addr_in(cfg_addr), .cfg_data_in(cfg_data),
    .coef_wr_in(coef_wr), .coef_sel_in(coef_sel),
    .coef_data_in(coef_data), .pix_valid_in(pix_valid),
    .pix_ready_out(pix_ready), .pix_r_in(pr), .pix_g_in(pg),
    .pix_b_in(pb), .out_valid_out(out_valid), .out_ready_in(out_ready),
    .green_port_out(gp), .blue_port_out(bp), .red_port_out(rp),
    .red_port_oe_out(red_oe), .bypass_out(byp), .fmt422_out(f422));
  rgbcsc_sink i_sink (.clk_sys_in, .rst_in, .stall_in(stall),
    .out_valid_in(out_valid), .word_in({red_oe, rp, bp, gp}),
    .ready_out(out_ready));
  initial
    forever #2.5 clk_sys_in = ~clk_sys_in;
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (pix_ready === 1'b0)
      saw_full = 1;
    if (cyc == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int color_matrix(int w, int g, int b, int r);
    int v;
    v = (cf[3*w] * g + cf[3*w+1] * b + cf[3*w+2] * r + 4096) >>> 13;
    if (w != 0)
      v = v + 512;
    return v < 0 ? 0 : (v > 1023 ? 1023 : v);
  endfunction
  // rounding style is the designer's, so up to t steps are tolerated
  function automatic bit near(logic [30:0] a, logic [30:0] e, int t);
    bit ok;
    int d;
    ok = (a[30] === e[30]);
    for (int f = 0; f < 30; f += 10)
    begin
      d = int'(a[f+:10]) - int'(e[f+:10]);
      ok &= (^a[f+:10] !== 1'bx) && d <= t && d >= -t;
    end
    return ok;
  endfunction
  task automatic chk(bit ok, string m);
    num_checks++;
    if (!ok)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic chkq(int from, logic [30:0] e0, logic [30:0] e1, int t);
    chk(i_sink.q.size() > from + 10, "too few words");
    for (int j = from; j < i_sink.q.size(); j++)
      chk(near(i_sink.q[j], j % 2 ? e1 : e0, t), "stream word");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (cf[i])
      cf[i] = dk[i];
  endtask
  task automatic wr(bit k, logic [7:0] a, logic [15:0] d);
    @(posedge clk_sys_in);
    cfg_wr <= !k;
    coef_wr <= k;
    cfg_addr <= a;
    coef_sel <= a[3:0];
    cfg_data <= d[7:0];
    coef_data <= d;
    @(posedge clk_sys_in);
    cfg_wr <= 1'b0;
    coef_wr <= 1'b0;
  endtask
  // md 0 ramp, 1 constant, 2 blue toggling at the nyquist rate
  task automatic send(int n, int md, int g, int b, int r);
    @(posedge clk_sys_in);
    for (int i = 0; i < n; i++)
    begin
      pix_valid <= 1'b1;
      pg <= 10'(md == 0 ? i : g);
      pb <= 10'(md == 0 ? i + 300 : (md == 2 ? (i % 2) * 1023 : b));
      pr <= 10'(md == 0 ? i + 600 : r);
      @(posedge clk_sys_in);
      while (pix_ready !== 1'b1)
        @(posedge clk_sys_in);
    end
    pix_valid <= 1'b0;
  endtask
  task automatic drain();
    repeat (8) @(posedge clk_sys_in);
    while (out_valid === 1'b1)
      @(posedge clk_sys_in);
  endtask
  ////////////////////////////////////////////////
  initial
  begin
    int g, b, r, st;
    logic [30:0] ew;
    do_reset();
    chk(byp === 1'b1 && f422 === 1'b0, "mode after reset");
    stall <= 1'b1;
    fork
      send(60, 0, 0, 0, 0);
      begin
        repeat (50) @(posedge clk_sys_in);
        stall <= 1'b0;
      end
    join
    drain();
    chk(saw_full, "input never refused");
    chk(i_sink.q.size() > 35, "too few words");
    // pixel 0 only primes the pipeline, so word j carries pixel j + 1
    foreach (i_sink.q[j])
    begin
      ew = {1'b1, 10'(j + 601), 10'(j + 301), 10'(j + 1)};
      chk(i_sink.q[j] === ew, "ramp word");
    end
    g = xs() % 1024;
    b = xs() % 1024;
    r = xs() % 1024;
    do_reset();
    wr(0, 8'h15, 16'h0002);
    send(50, 1, g, b, r);
    drain();
    chkq(14, {11'h000, 10'(b), 10'(g)}, {11'h000, 10'(r), 10'(g)}, 0);
    do_reset();
    wr(0, 8'h23, 16'h0000);
    wr(0, 8'h15, 16'h0002);
    wr(0, 8'h24, 16'h00FF);
    @(negedge clk_sys_in);
    chk(byp === 1'b0 && f422 === 1'b1, "mode writes");
    send(50, 1, g, b, r);
    drain();
    chkq(14, {11'h000, 10'(color_matrix(1, g, b, r)), 10'(color_matrix(0, g, b, r))},
      {11'h000, 10'(color_matrix(2, g, b, r)), 10'(color_matrix(0, g, b, r))}, 1);
    st = i_sink.q.size();
    for (int i = 0; i < 9; i++)
    begin
      cf[i] = int'(xs() % 8193) - 4096;
      wr(1, 8'(i), 16'(cf[i]));
    end
    wr(1, 8'h09, 16'h1234);
    send(60, 1, g, b, r);
    drain();
    chkq(st + 32, {11'h000, 10'(color_matrix(1, g, b, r)), 10'(color_matrix(0, g, b, r))},
      {11'h000, 10'(color_matrix(2, g, b, r)), 10'(color_matrix(0, g, b, r))}, 1);
    do_reset();
    wr(0, 8'h15, 16'h0002);
    send(60, 2, g, 0, r);
    drain();
    chkq(20, {11'h000, 10'h200, 10'(g)}, {11'h000, 10'(r), 10'(g)}, 2);
    give_verdict();
  end
endmodule
`default_nettype wire
